// >>> verilog/bsce_consts.svh
// constants for the bit, skip, compare and call execution block
`ifndef BSCE_CONSTS_SVH
`define BSCE_CONSTS_SVH
`define OPC_BITSET_HI 5'h10
`define OPC_TSTSKIP_HI 4'h9
`define OPC_BITTOG_HI 5'h07
`define OPC_CALL_HI 3'h7
`define OPC_CLEAR_FILE_OP_HI 7'h14
`define OPC_CMP_HI 8'h30
`define CMP_LESS_LO 8'h00
`define CMP_EQUAL_LO 8'h01
`define CMP_GREATER_LO 8'h02
`define OPC_WDT_CLEAR 16'h0004
`define OPC_NOP 16'h0000
`define PC_RESET 16'h0000
`define FLAG_RESET 1'b1
`define LATCH_RESET 8'h00
`endif

// >>> verilog/bsce_pkg.sv
// types shared by the execution block files
`default_nettype none
package bsce_pkg;
   typedef enum logic [1:0] {
      EX_RUN = 2'b00,
      EX_FLUSH = 2'b01
   } exec_state_t;
   typedef struct packed {
      logic wr_en;
      logic [7:0] addr;
      logic [7:0] data;
   } file_write_t;
   typedef struct packed {
      logic is_bit_set;
      logic is_skip_zero;
      logic is_skip_one;
      logic is_bit_toggle;
      logic is_call;
      logic is_clear_file;
      logic is_wdt_clear;
      logic is_cmp_equal;
      logic is_cmp_greater;
      logic is_cmp_less;
   } op_class_t;
endpackage
`default_nettype wire

// >>> verilog/bsce_decode.sv
// opcode classifier for the supported instruction group
`include "bsce_consts.svh"
`default_nettype none
module bsce_decode
   import bsce_pkg::*;
(
   input wire logic [15:0] opcode_in, // instruction word
   output op_class_t class_out // one-hot class
);
   wire logic [7:0] hi = opcode_in[15:8];
   // field compares on the high byte, watchdog clear on the whole word
   assign class_out.is_bit_set = (hi[7:3] == `OPC_BITSET_HI);
   assign class_out.is_skip_zero = (hi[7:4] == `OPC_TSTSKIP_HI) && hi[3];
   assign class_out.is_skip_one = (hi[7:4] == `OPC_TSTSKIP_HI) && !hi[3];
   assign class_out.is_bit_toggle = (hi[7:3] == `OPC_BITTOG_HI);
   assign class_out.is_call = (hi[7:5] == `OPC_CALL_HI);
   assign class_out.is_clear_file = (hi[7:1] == `OPC_CLEAR_FILE_OP_HI);
   assign class_out.is_wdt_clear = (opcode_in == `OPC_WDT_CLEAR);
   assign class_out.is_cmp_equal = (hi == (`OPC_CMP_HI | `CMP_EQUAL_LO));
   assign class_out.is_cmp_greater = (hi == (`OPC_CMP_HI | `CMP_GREATER_LO));
   assign class_out.is_cmp_less = (hi == (`OPC_CMP_HI | `CMP_LESS_LO));
endmodule
`default_nettype wire

// >>> verilog/bsce_compare.sv
// unsigned compare of file value against working register
`default_nettype none
module bsce_compare (
   input wire logic [7:0] file_in, // addressed location value
   input wire logic [7:0] work_in, // working register value
   output logic eq_out, // file equals working
   output logic gt_out, // file above working
   output logic lt_out // file below working
);
   wire logic [8:0] diff = {1'b0, file_in} - {1'b0, work_in};
   // borrow gives less, zero gives equal
   assign lt_out = diff[8];
   assign eq_out = (diff[7:0] == 8'h00);
   assign gt_out = !diff[8] && !eq_out;
endmodule
`default_nettype wire

// >>> verilog/bit_skip_compare_exec.sv
// execution unit for bit, skip, compare, short call, clear and watchdog ops
// Notes on behaviour
// - bit set forces chosen file bit to one, flags untouched, one cycle
// - test bit, skip next instruction when chosen bit is zero
// - test bit, skip next instruction when chosen bit is one
// - a taken skip replaces the fetched instruction by a no-op cycle
// - bit toggle inverts chosen bit of location, flags untouched
// - short call pushes pc plus one, loads literal and page latch
// - short call takes two cycles, second does nothing
// - clear file zeroes location, also working register when select is zero
// - watchdog clear resets counter and postscaler, sets timeout and powerdown
// - compare skips next when location equals working register
// - compare skips next when location is above working register
// - compare skips next when location is below working register
// - compares use unsigned 9-bit subtraction of working from location
`include "bsce_consts.svh"
`default_nettype none
module bit_skip_compare_exec
   import bsce_pkg::*;
(
   input wire logic sys_clk_in, // instruction clock
   input wire logic rst_b_in, // sync reset, active low
   input wire logic [15:0] opcode_in, // instruction in execution
   input wire logic [15:0] pc_in, // address of that instruction
   input wire logic [7:0] file_rd_in, // value of addressed location
   input wire logic [7:0] work_rd_in, // working register value
   output logic [7:0] file_addr_out, // addressed location
   output file_write_t file_wr_out, // location write
   output logic work_clr_out, // zero working register
   output logic [15:0] stack_top_out, // pushed return address
   output logic stack_push_out, // push strobe
   output logic [15:0] pc_load_out, // new program counter
   output logic pc_load_en_out, // load strobe
   output logic [7:0] pc_page_latch_out, // page latch value
   output logic page_latch_en_out, // page latch write strobe
   output logic wdt_clear_out, // reset counter and postscaler
   output logic timeout_flag_out, // timeout status bit
   output logic powerdown_flag_out, // powerdown status bit
   output logic flush_out, // current cycle is a no-op
   output logic busy_out // second cycle in progress
);
   // state, flags and the registered outputs with their next values
   op_class_t cls;
   exec_state_t state_q, state_d;
   logic eq, gt, lt;
   logic timeout_q, timeout_d;
   logic powerdown_q, powerdown_d;
   file_write_t wr_q, wr_d;
   logic work_clr_q, work_clr_d;
   logic push_q, push_d;
   logic pcld_q, pcld_d;
   logic latch_en_q, latch_en_d;
   logic wdtclr_q, wdtclr_d;
   logic [15:0] tos_q, tos_d;
   logic [15:0] pcnew_q, pcnew_d;
   logic [7:0] latch_q, latch_d;

   // class of the executing word
   bsce_decode u_decode (
      .opcode_in(opcode_in),
      .class_out(cls)
   );

   // compares touch no status flag, only borrow and zero are kept
   bsce_compare u_compare (
      .file_in(file_rd_in),
      .work_in(work_rd_in),
      .eq_out(eq),
      .gt_out(gt),
      .lt_out(lt)
   );

   // one-hot mask from the 3-bit field
   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = 8'h01 << sel;
   endfunction

   // opcode fields
   wire logic [7:0] loc_addr = opcode_in[7:0];
   wire logic [12:0] k_lit = opcode_in[12:0];
   wire logic clr_sel = opcode_in[8];
   wire logic [2:0] bsel = opcode_in[10:8];

   // executing means not in the discarded slot
   // gating every action by live keeps a discarded word from acting
   wire logic live = (state_q == EX_RUN);
   wire logic bit_val = |(file_rd_in & bit_mask(bsel));
   wire logic [7:0] set_val = file_rd_in | bit_mask(bsel);
   wire logic [7:0] tog_val = file_rd_in ^ bit_mask(bsel);
   wire logic skip_bit = (cls.is_skip_zero && !bit_val)
      || (cls.is_skip_one && bit_val);
   wire logic skip_cmp = (cls.is_cmp_equal && eq)
      || (cls.is_cmp_greater && gt)
      || (cls.is_cmp_less && lt);
   wire logic take_skip = live && (skip_bit || skip_cmp);
   wire logic take_call = live && cls.is_call;
   wire logic [15:0] pc_next = pc_in + 16'h0001;

   // sequence: run, or flush the fetched word
   // one flush cycle suffices since fetch has already moved past that word
   always_comb begin
      state_d = EX_RUN;
      case (state_q)
         EX_RUN: begin
            if (take_skip || take_call) begin
               state_d = EX_FLUSH;
            end
         end
         EX_FLUSH: state_d = EX_RUN;
         default: state_d = EX_RUN;
      endcase
   end

   // file writes for bit and clear ops
   // the classes never overlap, so the order of tests is free
   always_comb begin
      wr_d = '0;
      wr_d.addr = loc_addr;
      if (live && cls.is_bit_set) begin
         wr_d.wr_en = 1'b1;
         wr_d.data = set_val;
      end else if (live && cls.is_bit_toggle) begin
         wr_d.wr_en = 1'b1;
         wr_d.data = tog_val;
      end else if (live && cls.is_clear_file) begin
         wr_d.wr_en = 1'b1;
         wr_d.data = 8'h00;
      end
   end

   // working register cleared only when the select bit is zero
   assign work_clr_d = live && cls.is_clear_file && !clr_sel;

   // call strobes fire together, in the cycle after the call word
   assign push_d = take_call;
   assign pcld_d = take_call;
   assign latch_en_d = take_call;

   // short call: return address, target and page latch
   always_comb begin
      tos_d = tos_q;
      pcnew_d = pcnew_q;
      latch_d = latch_q;
      if (take_call) begin
         tos_d = pc_next;
         pcnew_d = {pc_in[15:13], k_lit};
         latch_d = {pc_in[15:13], k_lit[12:8]};
      end
   end

   // watchdog strobe
   assign wdtclr_d = live && cls.is_wdt_clear;

   // status flags only ever set, here or by reset; no input clears them
   always_comb begin
      timeout_d = timeout_q;
      powerdown_d = powerdown_q;
      if (wdtclr_d) begin
         timeout_d = 1'b1;
         powerdown_d = 1'b1;
      end
   end

   // execution state
   // back to run on reset, so no flush follows it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         state_q <= EX_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // timeout flag
   // set here only, by reset or watchdog clear; no input clears it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         timeout_q <= `FLAG_RESET;
      end else begin
         timeout_q <= timeout_d;
      end
   end

   // powerdown flag
   // same ownership as the timeout flag
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         powerdown_q <= `FLAG_RESET;
      end else begin
         powerdown_q <= powerdown_d;
      end
   end

   // page latch value
   // holds between calls so later branches can use it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         latch_q <= `LATCH_RESET;
      end else begin
         latch_q <= latch_d;
      end
   end

   // file write, a one-cycle pulse
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         wr_q <= '0;
      end else begin
         wr_q <= wr_d;
      end
   end

   // working register clear pulse
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         work_clr_q <= 1'b0;
      end else begin
         work_clr_q <= work_clr_d;
      end
   end

   // stack push pulse
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         push_q <= 1'b0;
      end else begin
         push_q <= push_d;
      end
   end

   // program counter load pulse
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         pcld_q <= 1'b0;
      end else begin
         pcld_q <= pcld_d;
      end
   end

   // page latch write pulse
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         latch_en_q <= 1'b0;
      end else begin
         latch_en_q <= latch_en_d;
      end
   end

   // watchdog clear pulse
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         wdtclr_q <= 1'b0;
      end else begin
         wdtclr_q <= wdtclr_d;
      end
   end

   // return address
   // kept until the next call overwrites it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         tos_q <= `PC_RESET;
      end else begin
         tos_q <= tos_d;
      end
   end

   // call target
   // kept until the next call overwrites it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         pcnew_q <= `PC_RESET;
      end else begin
         pcnew_q <= pcnew_d;
      end
   end

   // file side outputs
   assign file_addr_out = loc_addr;
   assign file_wr_out = wr_q;
   assign work_clr_out = work_clr_q;

   // call side outputs
   assign stack_top_out = tos_q;
   assign stack_push_out = push_q;
   assign pc_load_out = pcnew_q;
   assign pc_load_en_out = pcld_q;
   assign pc_page_latch_out = latch_q;
   assign page_latch_en_out = latch_en_q;

   // watchdog and status outputs
   assign wdt_clear_out = wdtclr_q;
   assign timeout_flag_out = timeout_q;
   assign powerdown_flag_out = powerdown_q;

   // no-op slot, busy mirrors it for the fetch stall
   assign flush_out = !live;
   assign busy_out = !live;
endmodule
`default_nettype wire

// >>> tb/bsce_props.sv
// checker for the bit, skip, compare and call execution block
`default_nettype none
module bsce_props
   import bsce_pkg::*;
(
   input wire logic sys_clk_in, // clock
   input wire logic rst_b_in, // reset
   input wire logic [15:0] opcode_in, // op
   input wire logic [15:0] pc_in, // pc
   input wire logic [7:0] file_rd_in, // file
   input wire logic [7:0] work_rd_in, // work
   input wire file_write_t file_wr_out, // write
   input wire logic work_clr_out, // wclr
   input wire logic [15:0] stack_top_out, // ret
   input wire logic stack_push_out, // push
   input wire logic [15:0] pc_load_out, // pc
   input wire logic pc_load_en_out, // ld
   input wire logic [7:0] pc_page_latch_out, // page
   input wire logic page_latch_en_out, // pg ld
   input wire logic wdt_clear_out, // wdt
   input wire logic timeout_flag_out, // to
   input wire logic powerdown_flag_out, // pd
   input wire logic flush_out // slot
);
   timeunit 1ns;
   timeprecision 100ps;
   // decoded views of the executing opcode
   wire logic go = !flush_out;
   wire logic [7:0] hi = opcode_in[15:8];
   wire logic bit_take = file_rd_in[opcode_in[10:8]] != opcode_in[11];
   wire logic cmp_take = hi[1] ? file_rd_in > work_rd_in
      : hi[0] ? file_rd_in == work_rd_in : file_rd_in < work_rd_in;
   wire logic [7:0] mask = 8'h01 << opcode_in[10:8];
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   bit_set_a:
   assert property (go && hi[7:3] == 5'h10 |=> file_wr_out ==
      {1'b1, $past(opcode_in[7:0]), $past(file_rd_in) | $past(mask)}) else $error("bad bit set");
   bit_tog_a:
   assert property (go && hi[7:3] == 5'h07 |=> file_wr_out ==
      {1'b1, $past(opcode_in[7:0]), $past(file_rd_in) ^ $past(mask)}) else $error("bad toggle");
   clr_file_a:
   assert property (go && hi[7:1] == 7'h14 |=> file_wr_out == {1'b1, $past(opcode_in[7:0]), 8'h00}
      && work_clr_out == !$past(opcode_in[8])) else $error("bad clear");
   test_skip_a:
   assert property (go && hi[7:4] == 4'h9 |=> flush_out == $past(bit_take)) else $error("bad test");
   cmp_skip_a:
   assert property (go && hi inside {8'h30, 8'h31, 8'h32} |=> flush_out == $past(cmp_take))
      else $error("bad compare");
   short_call_a:
   assert property (go && hi[7:5] == 3'h7 |=> stack_push_out && pc_load_en_out && page_latch_en_out
      && flush_out && stack_top_out == $past(pc_in) + 16'h0001
      && pc_load_out == {$past(pc_in[15:13]), $past(opcode_in[12:0])}
      && pc_page_latch_out == {$past(pc_in[15:13]), $past(opcode_in[12:8])}) else $error("bad call");
   wdt_clr_a:
   assert property (go && opcode_in == 16'h0004 |=> wdt_clear_out && timeout_flag_out
      && powerdown_flag_out) else $error("bad watchdog clear");
   noop_slot_a:
   assert property (flush_out |=> !file_wr_out.wr_en && !stack_push_out && !wdt_clear_out
      && !flush_out) else $error("no-op slot acted");
   cover property (go && hi[7:5] == 3'h7);
   cover property (go && hi[7:4] == 4'h9 && bit_take);
   cover property (go && hi == 8'h32 && cmp_take);
endmodule
`default_nettype wire

// >>> tb/tb_bit_skip_compare_exec.sv
// self-checking bench for the execution block
`default_nettype none
module tb_bit_skip_compare_exec import bsce_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_in, rst_b_in = 1'b0;
   logic [15:0] opcode_in = 16'h0000, pc_in = 16'h0000, stack_top_out, pc_load_out;
   logic [7:0] file_rd_in = 8'h00, work_rd_in = 8'h00, pc_page_latch_out, file_addr_out;
   file_write_t file_wr_out;
   logic work_clr_out, stack_push_out, pc_load_en_out, page_latch_en_out, wdt_clear_out;
   logic timeout_flag_out, powerdown_flag_out, flush_out, busy_out;
   int n_fail = 0, checks_done = 0;
   bit_skip_compare_exec dut_u (.sys_clk_in, .rst_b_in, .opcode_in, .pc_in, .file_rd_in,
      .work_rd_in, .file_addr_out, .file_wr_out, .work_clr_out, .stack_top_out, .stack_push_out,
      .pc_load_out, .pc_load_en_out, .pc_page_latch_out, .page_latch_en_out, .wdt_clear_out,
      .timeout_flag_out, .powerdown_flag_out, .flush_out, .busy_out);
   // 40 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // present one opcode, return 2 ns after the edge that took it
   task automatic step(input logic [15:0] op, input logic [7:0] f);
      opcode_in = op;
      file_rd_in = f;
      @(posedge sys_clk_in);
      #2;
   endtask
   // a taken skip swallows the next bit set, an untaken one lets it write
   task automatic skip_case(input logic [15:0] op, input logic [7:0] f, input logic take);
      step(op, f);
      chk(flush_out, take);
      chk(busy_out, take);
      step(16'h8001, 8'h00);
      chk(file_wr_out.wr_en, !take);
      step(16'h0000, 8'h00);
   endtask
   task automatic t_bits();
      for (int b = 0; b < 8; b++) begin
         step({5'h10, b[2:0], 8'h3c}, 8'h0a);
         chk(file_wr_out, {1'b1, 8'h3c, 8'h0a | (8'h01 << b)});
         chk(file_addr_out, 8'h3c);
         step({5'h07, b[2:0], 8'hc3}, 8'h5a);
         chk(file_wr_out, {1'b1, 8'hc3, 8'h5a ^ (8'h01 << b)});
         skip_case({5'h13, b[2:0], 8'h10}, 8'h96, !b[0] ^ b[1] ^ b[2]);
         skip_case({5'h12, b[2:0], 8'h10}, 8'h69, !b[0] ^ b[1] ^ b[2]);
      end
      for (int s = 0; s < 2; s++) begin
         step({7'h14, s[0], 8'h21}, 8'hff);
         chk({file_wr_out, work_clr_out}, {1'b1, 8'h21, 8'h00, !s[0]});
      end
   endtask
   task automatic t_cmp();
      logic [7:0] fv [5] = '{8'h05, 8'h06, 8'h04, 8'hff, 8'h01};
      logic [7:0] wv [5] = '{8'h05, 8'h05, 8'h05, 8'h01, 8'hff};
      for (int i = 0; i < 5; i++) begin
         work_rd_in = wv[i];
         skip_case(16'h3140, fv[i], fv[i] == wv[i]);
         skip_case(16'h3240, fv[i], fv[i] > wv[i]);
         skip_case(16'h3040, fv[i], fv[i] < wv[i]);
      end
   endtask
   // literal kept within the short call reach
   task automatic t_call();
      pc_in = 16'ha123;
      step(16'hfabc, 8'h00);
      chk({stack_push_out, pc_load_en_out, page_latch_en_out, flush_out}, 4'hf);
      chk({stack_top_out, pc_page_latch_out}, {16'ha124, 8'hba});
      chk(pc_load_out, 16'hbabc);
      step(16'h0004, 8'h00);
      chk({wdt_clear_out, stack_push_out, flush_out}, 3'b000);
      step(16'h0004, 8'h00);
      chk({wdt_clear_out, timeout_flag_out, powerdown_flag_out}, 3'b111);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk_in);
      #2;
      chk({flush_out, timeout_flag_out, powerdown_flag_out}, 3'b011);
      rst_b_in = 1'b1;
      t_bits();
      t_cmp();
      t_call();
      finish_test();
   end
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
endmodule
bind bit_skip_compare_exec bsce_props chk_u (.sys_clk_in, .rst_b_in, .opcode_in, .pc_in,
   .file_rd_in, .work_rd_in, .file_wr_out, .work_clr_out, .stack_top_out, .stack_push_out,
   .pc_load_out, .pc_load_en_out, .pc_page_latch_out, .page_latch_en_out, .wdt_clear_out,
   .timeout_flag_out, .powerdown_flag_out, .flush_out);
`default_nettype wire
